/* src/bstap_top.sv */
// boundary-scan test access port: tap controller, instruction and data registers
`timescale 1ns/10ps
//
// Summary of operation
// - all scanning paced by test clock edges
// - three-bit instruction, shifted lsb first
// - instruction selects test and serial path
// - code 000 puts chain in path
// - extest drives pins from updated pattern
// - code 100 samples, core path kept
// - code 110 connects identification register
// - code 111 gives one-clock bypass delay
// - identification 32 bits, lsb out first
// - id bit0 one, maker, part, revision
// - bypass is one single stage
// - 98-bit chain used only by extest/sample
// - sixteen-state controller, dr and ir branches
// - next state from tms at rising edge
// - five tms-high edges force reset
// - reset state loads idcode, normal operation
// - chain outputs update on falling edge only
module bstap_top
  import bstap_pkg::*;
#(
  parameter int          WIDTH     = CHAIN_WIDTH,
  parameter logic [10:0] MFR_CODE  = 11'h2AA,   // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1234,  // arbitrary value
  parameter logic [3:0]  REV_CODE  = 4'h1       // arbitrary value
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             tck_i,
  input  wire logic             tms_i,
  input  wire logic             tdi_i,
  output logic                  tdo_o,
  output logic                  tdo_oe_o,
  input  wire logic [WIDTH-1:0] pin_in_i,
  input  wire logic [WIDTH-1:0] core_out_i,
  input  wire logic [WIDTH-1:0] pin_sample_i,
  output logic      [WIDTH-1:0] pin_out_o,
  output logic                  test_mode_o
);

  // ---------------------------------------------------------------
  // pin synchronisers and test clock edge detection
  // ---------------------------------------------------------------
  logic [2:0]  tck_q, tck_d;
  logic [2:0]  tms_q, tms_d;
  logic [2:0]  tdi_q, tdi_d;
  logic        tck_lvl_q, tck_lvl_d;
  bstap_pins_t pins;

  always_comb begin
    tck_d     = {tck_q[1:0], tck_i};
    tms_d     = {tms_q[1:0], tms_i};
    tdi_d     = {tdi_q[1:0], tdi_i};
    tck_lvl_d = tck_lvl_q;
    if (tck_q[1] == tck_q[2]) begin
      tck_lvl_d = tck_q[2];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tck_q     <= 3'h0;
      tms_q     <= 3'h7;
      tdi_q     <= 3'h0;
      tck_lvl_q <= 1'b0;
    end else begin
      tck_q     <= tck_d;
      tms_q     <= tms_d;
      tdi_q     <= tdi_d;
      tck_lvl_q <= tck_lvl_d;
    end
  end

  // edges on agreed tck level; tms/tdi taken at the same depth
  always_comb begin
    pins.tms  = tms_q[2];
    pins.tdi  = tdi_q[2];
    pins.rise = (tck_q[1] == tck_q[2]) && tck_q[2] && !tck_lvl_q;
    pins.fall = (tck_q[1] == tck_q[2]) && !tck_q[2] && tck_lvl_q;
  end

  // ---------------------------------------------------------------
  // tap controller
  // ---------------------------------------------------------------
  bstap_state_t state_q, state_d;

  function automatic bstap_state_t next_state(bstap_state_t s, logic tms);
    bstap_state_t n;
    n = s;
    case (s)
      ST_RESET:    n = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   n = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   n = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      default:     n = ST_RESET;
    endcase
    return n;
  endfunction

  // five tms-high rising edges reach reset from any state by the arcs
  always_comb begin
    state_d = state_q;
    if (pins.rise) begin
      state_d = next_state(state_q, pins.tms);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // instruction register
  // ---------------------------------------------------------------
  logic [IR_WIDTH-1:0] ir_shift_q, ir_shift_d;
  logic [IR_WIDTH-1:0] ir_q, ir_d;

  always_comb begin
    ir_shift_d = ir_shift_q;
    ir_d       = ir_q;
    if (state_q == ST_RESET) begin
      ir_d = IR_RESET_VALUE;
    end else if (pins.rise) begin
      case (state_q)
        ST_CAP_IR: begin
          ir_shift_d = {{(IR_WIDTH-2){1'b0}}, IR_CAPTURE_LSB};
        end
        ST_SHIFT_IR: begin
          ir_shift_d = {pins.tdi, ir_shift_q[IR_WIDTH-1:1]};
        end
        default: begin
        end
      endcase
    end else if (pins.fall && state_q == ST_UPD_IR) begin
      ir_d = ir_shift_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ir_shift_q <= '0;
      ir_q       <= IR_RESET_VALUE;
    end else begin
      ir_shift_q <= ir_shift_d;
      ir_q       <= ir_d;
    end
  end

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  bstap_sel_t sel;
  logic       extest;

  always_comb begin
    case (ir_q)
      INSN_EXTEST, INSN_SAMPLE: sel = SEL_CHAIN;
      INSN_IDCODE:              sel = SEL_ID;
      default:                  sel = SEL_BYPASS;
    endcase
  end

  // extest releases the pins whenever the controller sits in reset
  assign extest      = (ir_q == INSN_EXTEST) && (state_q != ST_RESET);
  assign test_mode_o = extest;

  // ---------------------------------------------------------------
  // identification register and bypass stage
  // ---------------------------------------------------------------
  logic [ID_WIDTH-1:0] identification_shift_register_q;
  logic [ID_WIDTH-1:0] identification_shift_register_d;
  logic                single_bit_bypass_stage_q;
  logic                single_bit_bypass_stage_d;
  logic [ID_WIDTH-1:0] id_value;
  logic                dr_rise_cap;
  logic                dr_rise_shift;

  // id word is fixed; only capture-dr reloads the shift copy
  always_comb begin
    id_value                          = '0;
    id_value[ID_FIXED_POS]            = ID_FIXED_BIT;
    id_value[ID_PART_LSB-1:ID_MFR_LSB] = MFR_CODE;
    id_value[ID_REV_LSB-1:ID_PART_LSB] = PART_CODE;
    id_value[ID_WIDTH-1:ID_REV_LSB]   = REV_CODE;
  end

  assign dr_rise_cap   = pins.rise && state_q == ST_CAP_DR;
  assign dr_rise_shift = pins.rise && state_q == ST_SHIFT_DR;

  always_comb begin
    identification_shift_register_d = identification_shift_register_q;
    single_bit_bypass_stage_d       = single_bit_bypass_stage_q;
    if (dr_rise_cap && sel == SEL_ID) begin
      identification_shift_register_d = id_value;
    end else if (dr_rise_shift && sel == SEL_ID) begin
      identification_shift_register_d =
        {pins.tdi, identification_shift_register_q[ID_WIDTH-1:1]};
    end
    if (dr_rise_cap && sel == SEL_BYPASS) begin
      single_bit_bypass_stage_d = 1'b0;
    end else if (dr_rise_shift && sel == SEL_BYPASS) begin
      single_bit_bypass_stage_d = pins.tdi;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      identification_shift_register_q <= '0;
      single_bit_bypass_stage_q       <= 1'b0;
    end else begin
      identification_shift_register_q <= identification_shift_register_d;
      single_bit_bypass_stage_q       <= single_bit_bypass_stage_d;
    end
  end

  // ---------------------------------------------------------------
  // pin scan chain
  // ---------------------------------------------------------------
  logic             chain_tdo;
  logic [WIDTH-1:0] chain_latched;
  logic [WIDTH-1:0] chain_capture;

  // extest captures input pins, sample sees pin-side values
  assign chain_capture = (ir_q == INSN_EXTEST) ? pin_in_i : pin_sample_i;

  bstap_chain #(
    .WIDTH(WIDTH)
  ) u_pin_scan_chain (
    .core_clk_i(core_clk_i),
    .rst_i     (rst_i),
    .capture_i (dr_rise_cap && sel == SEL_CHAIN),
    .shift_i   (dr_rise_shift && sel == SEL_CHAIN),
    .update_i  (pins.fall && state_q == ST_UPD_DR && sel == SEL_CHAIN),
    .tdi_i     (pins.tdi),
    .pins_i    (chain_capture),
    .tdo_o     (chain_tdo),
    .latched_o (chain_latched)
  );

  assign pin_out_o = extest ? chain_latched : core_out_i;

  // ---------------------------------------------------------------
  // serial output, retimed on the falling test clock edge
  // ---------------------------------------------------------------
  logic tdo_q, tdo_d;
  logic oe_q, oe_d;
  logic dr_bit;

  always_comb begin
    case (sel)
      SEL_CHAIN: dr_bit = chain_tdo;
      SEL_ID:    dr_bit = identification_shift_register_q[0];
      default:   dr_bit = single_bit_bypass_stage_q;
    endcase
    tdo_d = tdo_q;
    oe_d  = oe_q;
    // a released tdo is parked low so no stale shift bit lingers on it
    if (pins.fall) begin
      oe_d  = (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);
      tdo_d = 1'b0;
      if (state_q == ST_SHIFT_IR) begin
        tdo_d = ir_shift_q[0];
      end else if (state_q == ST_SHIFT_DR) begin
        tdo_d = dr_bit;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  assign tdo_o    = tdo_q;
  assign tdo_oe_o = oe_q;

endmodule

/* src/bstap_pkg.sv */
// package: tap states, instruction codes, chain widths and id fields
package bstap_pkg;

  localparam int          IR_WIDTH       = 3;
  localparam int          ID_WIDTH       = 32;
  localparam int          CHAIN_WIDTH    = 98;
  localparam int          TRST_TMS_EDGES = 5;

  localparam logic [2:0]  INSN_EXTEST    = 3'h0;
  localparam logic [2:0]  INSN_SAMPLE    = 3'h4;
  localparam logic [2:0]  INSN_IDCODE    = 3'h6;
  localparam logic [2:0]  INSN_BYPASS    = 3'h7;
  localparam logic [2:0]  IR_RESET_VALUE = INSN_IDCODE;
  localparam logic [1:0]  IR_CAPTURE_LSB = 2'h1;

  localparam int          ID_FIXED_POS   = 0;
  localparam int          ID_MFR_LSB     = 1;
  localparam int          ID_PART_LSB    = 12;
  localparam int          ID_REV_LSB     = 28;
  localparam logic [0:0]  ID_FIXED_BIT   = 1'h1;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bstap_state_t;

  typedef enum logic [1:0] {
    SEL_CHAIN, SEL_ID, SEL_BYPASS
  } bstap_sel_t;

  // synchronised test pins and edge strobes
  typedef struct packed {
    logic tms;
    logic tdi;
    logic rise;
    logic fall;
  } bstap_pins_t;

endpackage

/* src/bstap_chain.sv */
// pin scan chain: shift stages plus latched parallel outputs
`timescale 1ns/10ps
module bstap_chain
  import bstap_pkg::*;
#(
  parameter int WIDTH = CHAIN_WIDTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             capture_i,
  input  wire logic             shift_i,
  input  wire logic             update_i,
  input  wire logic             tdi_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic                  tdo_o,
  output logic      [WIDTH-1:0] latched_o
);

  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] shift_d;
  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] latch_d;

  always_comb begin
    shift_d = shift_q;
    latch_d = latch_q;
    if (capture_i) begin
      shift_d = pins_i;
    end else if (shift_i) begin
      shift_d = {tdi_i, shift_q[WIDTH-1:1]};
    end
    if (update_i) begin
      latch_d = shift_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shift_q <= '0;
      latch_q <= '0;
    end else begin
      shift_q <= shift_d;
      latch_q <= latch_d;
    end
  end

  assign tdo_o     = shift_q[0];
  assign latched_o = latch_q;

endmodule

/* verification/bstap_tester.sv */
// tester model: drives tck, tms and tdi and reads the tdo line
`timescale 1ns/10ps
module bstap_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic line;
  // released tdo line is pulled up
  assign line = tdo_oe_i ? tdo_i : 1'b1;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // one test clock period; tck stands low between calls
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #62;
    tdo = line;
    tck_o = 1'b1;
    #63;
    tck_o = 1'b0;
  endtask
  // n bits lsb first, tms high with the last
  task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
  endtask
  task automatic ir(input logic [2:0] code, output logic [127:0] dout);
    logic d;
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    scan(3, {125'h0, code}, dout);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
  task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    logic d;
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    scan(n, din, dout);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
  task automatic tap_reset();
    logic d;
    for (int i = 0; i < 5; i++) begin
      step(1'b1, 1'b0, d);
    end
    step(1'b0, 1'b0, d);
  endtask
endmodule

/* verification/bstap_top_asserts.sv */
// checker: port-level timing of the test access port
`timescale 1ns/10ps
module bstap_top_asserts
  import bstap_pkg::*;
#(
  parameter int WIDTH = CHAIN_WIDTH
) (
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  input wire logic             tck_i,
  input wire logic             tms_i,
  input wire logic             tdi_i,
  input wire logic             tdo_o,
  input wire logic             tdo_oe_o,
  input wire logic [WIDTH-1:0] pin_in_i,
  input wire logic [WIDTH-1:0] core_out_i,
  input wire logic [WIDTH-1:0] pin_sample_i,
  input wire logic [WIDTH-1:0] pin_out_o,
  input wire logic             test_mode_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // --------------------------------------------------
  // helper: count tck rises with tms high
  // --------------------------------------------------
  logic [1:0] tck_q;
  logic [2:0] hi_q;
  logic [2:0] hi_d;
  always_comb begin
    hi_d = hi_q;
    if (tck_q[0] && !tck_q[1]) begin
      hi_d = !tms_i ? 3'h0 : ((hi_q == 3'h7) ? hi_q : hi_q + 3'h1);
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tck_q <= 2'h0;
      hi_q  <= 3'h0;
    end else begin
      tck_q <= {tck_q[0], tck_i};
      hi_q  <= hi_d;
    end
  end
  sequence tck_low_s;
    !tck_i && !$past(tck_i, 2);
  endsequence
  sequence quiet_s;
    !test_mode_o && !tdo_oe_o;
  endsequence
  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  tdo_edge_a: assert property (!$stable(tdo_o) |-> tck_low_s)
    else $error("tdo changed away from a tck fall");
  oe_edge_a: assert property (!$stable(tdo_oe_o) |-> tck_low_s)
    else $error("tdo enable changed away from a tck fall");
  tdo_quiet_a: assert property (!tdo_oe_o |-> !tdo_o)
    else $error("tdo high while released");
  core_path_a: assert property (!test_mode_o |-> pin_out_o == core_out_i)
    else $error("pins not driven by core outside extest");
  reset_state_a: assert property ($fell(rst_i) |-> (quiet_s and !tdo_o))
    else $error("test logic active after reset");
  mode_edge_a: assert property ($rose(test_mode_o) |-> tck_low_s)
    else $error("extest entered away from a tck fall");
  latch_edge_a: assert property (test_mode_o && $past(test_mode_o) && !$stable(pin_out_o)
    |-> tck_low_s)
    else $error("latched pins changed away from a tck fall");
  tms_reset_a: assert property (hi_q == 3'h5 |-> ##[0:10] quiet_s)
    else $error("five tms-high edges did not reset the port");
endmodule
bind bstap_top bstap_top_asserts #(.WIDTH(WIDTH)) chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .pin_in_i(pin_in_i), .core_out_i(core_out_i), .pin_sample_i(pin_sample_i),
  .pin_out_o(pin_out_o), .test_mode_o(test_mode_o));

/* verification/tb_boundary_scan_tap.sv */
// testbench: instruction table, reset and preload cases for the tap
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module tb_boundary_scan_tap;
  import bstap_pkg::*;
  typedef struct packed {
    logic [2:0]   code;
    logic [7:0]   n;
    logic [127:0] din;
    logic [127:0] exp;
  } bstap_row_t;
  localparam logic [31:0] ID_EXP = {4'h9, 16'hC3A5, 11'h155, 1'h1};
  localparam logic [97:0] PIN_A  = {49{2'h2}};
  localparam logic [97:0] PIN_B  = {7{14'h1A5C}};
  localparam logic [97:0] PIN_C  = {14{7'h35}};
  localparam logic [97:0] PAT_E  = {14{7'h4B}};
  localparam logic [97:0] PAT_S  = {7{14'h00F3}};
  localparam bstap_row_t ROWS [8] = '{
    '{3'h6, 8'h20, 128'h0, ID_EXP}, '{3'h7, 8'h08, 128'hB5, 128'h6A},
    '{3'h1, 8'h08, 128'hB5, 128'h6A}, '{3'h2, 8'h08, 128'hB5, 128'h6A},
    '{3'h3, 8'h08, 128'hB5, 128'h6A}, '{3'h5, 8'h08, 128'hB5, 128'h6A},
    '{3'h0, 8'h62, PAT_E, PIN_A}, '{3'h4, 8'h62, PAT_S, PIN_B}};
  logic          core_clk_i;
  logic          rst_i;
  logic          tck;
  logic          tms;
  logic          tdi;
  logic          tdo;
  logic          tdo_oe;
  logic [97:0]   pin_in;
  logic [97:0]   core_out;
  logic [97:0]   pin_sample;
  logic [97:0]   pin_out_o;
  logic          test_mode_o;
  logic [127:0]  dout;
  int            n_fail;
  int            n_tests;
  int            cycles;
  bstap_top #(.WIDTH(98), .MFR_CODE(11'h155), .PART_CODE(16'hC3A5), .REV_CODE(4'h9)) uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_in_i(pin_in), .core_out_i(core_out),
    .pin_sample_i(pin_sample), .pin_out_o(pin_out_o), .test_mode_o(test_mode_o));
  bstap_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic load_ir(input logic [2:0] code);
    logic [127:0] cap;
    tester.ir(code, cap);
    `CHK("ir capture", 3'h1, cap[2:0])
  endtask
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    logic d;
    n_fail = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    pin_in = PIN_A;
    pin_sample = PIN_B;
    core_out = PIN_C;
    repeat (6) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK("tdo_oe_o", 1'b0, tdo_oe)
    `CHK("pin_out_o", PIN_C, pin_out_o)
    tester.step(1'b0, 1'b0, d);
    tester.dr(32, 128'h0, dout);
    `CHK("reset idcode", ID_EXP, dout[31:0])
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      load_ir(ROWS[i].code);
      tester.dr(int'(ROWS[i].n), ROWS[i].din, dout);
      `CHK("scan out", ROWS[i].exp, dout)
      `CHK("pin_out_o", (ROWS[i].code == 3'h0) ? ROWS[i].din[97:0] : PIN_C, pin_out_o)
      `CHK("test_mode_o", ROWS[i].code == 3'h0, test_mode_o)
      $display("row %0d done", i);
    end
    // pattern preloaded under sample appears once extest is loaded
    load_ir(3'h0);
    `CHK("preload pins", PAT_S, pin_out_o)
    $display("preload test done");
    tester.tap_reset();
    `CHK("test_mode_o", 1'b0, test_mode_o)
    `CHK("pin_out_o", PIN_C, pin_out_o)
    tester.dr(32, 128'h0, dout);
    `CHK("idcode after reset", ID_EXP, dout[31:0])
    $display("tms reset test done");
    // reset pin in mid-run while extest is active
    load_ir(3'h0);
    `CHK("test_mode_o", 1'b1, test_mode_o)
    @(posedge core_clk_i);
    #1 rst_i = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    `CHK("tdo_oe_o", 1'b0, tdo_oe)
    `CHK("test_mode_o", 1'b0, test_mode_o)
    `CHK("pin_out_o", PIN_C, pin_out_o)
    tester.step(1'b0, 1'b0, d);
    tester.dr(32, 128'h0, dout);
    `CHK("idcode after pin reset", ID_EXP, dout[31:0])
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
